/* File: rdc_consts.vh */
`ifndef RDC_CONSTS_VH
`define RDC_CONSTS_VH

// ----------------------------------------
// register offsets (7-bit word address)
// ----------------------------------------
`define RDC_ADDR_THRESH    7'h01
`define RDC_ADDR_ADAPT     7'h02
`define RDC_ADDR_SYNTH     7'h05
`define RDC_ADDR_RATE      7'h07
`define RDC_ADDR_PERSIST   7'h0a
`define RDC_ADDR_SCALE     7'h0d
`define RDC_ADDR_STATUS    7'h0f

// ----------------------------------------
// field positions
// ----------------------------------------
`define RDC_FCW_MSB        11
`define RDC_RATE_MSB       11
`define RDC_RATE_LSB       10
`define RDC_ADAPT_BIT      6
`define RDC_SCALE_MSB      1

// ----------------------------------------
// reset values
// ----------------------------------------
`define RDC_RST_SYNTH      16'h0000
`define RDC_RST_ADAPT      16'h0000
`define RDC_RST_SCALE      16'h0000

// ----------------------------------------
// quad-state strap levels
// ----------------------------------------
`define RDC_QS_GND         2'h0
`define RDC_QS_OPEN        2'h1
`define RDC_QS_RES         2'h2
`define RDC_QS_VDD         2'h3

// ----------------------------------------
// strap-selected defaults, indexed by strap level
// ----------------------------------------
`define RDC_THR_DEF0       16'h0040
`define RDC_THR_DEF1       16'h0080
`define RDC_THR_DEF2       16'h0100
`define RDC_THR_DEF3       16'h0200
`define RDC_HOLD_DEF0      16'h0064
`define RDC_HOLD_DEF1      16'h03e8
`define RDC_HOLD_DEF2      16'h2710
`define RDC_HOLD_DEF3      16'hffff

// ----------------------------------------
// timing
// ----------------------------------------
`define RDC_CLK_PERIOD_NS  20
`define RDC_TICK_NS        1000
`define RDC_TICK_CYCLES    (`RDC_TICK_NS / `RDC_CLK_PERIOD_NS)
`define RDC_PRT_US0        20'd250
`define RDC_PRT_US1        20'd500
`define RDC_PRT_US2        20'd1000
`define RDC_PRT_US3        20'd2000

// ----------------------------------------
// serial frame: write bit, 7-bit address, 16-bit data
// ----------------------------------------
`define RDC_FRAME_BITS     5'd24
`define RDC_HDR_BITS       5'd8

`endif

/* File: rdc_sync.v */
`timescale 1ns/1ps

// ----------------------------------------
// two-stage synchroniser
// ----------------------------------------
module rdc_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             resetn,
    // data
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage1;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

/* File: rdc_radar_config.v */
`include "rdc_consts.vh"
`timescale 1ns/1ps

module rdc_radar_config #(
    parameter TICK_CYCLES = `RDC_TICK_CYCLES
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // serial port pins and host reset
    input  wire        spi_sclk,
    input  wire        spi_mosi,
    input  wire        spi_cs_n,
    output reg         spi_miso,
    output wire        spi_miso_oe,
    input  wire        radar_reset_n,
    // strap pins, level-coded
    input  wire [1:0]  mode_strap_pin,
    input  wire [1:0]  thresh_strap_pin,
    input  wire [1:0]  hold_strap_pin,
    input  wire [1:0]  rate_strap_pin,
    // detector front end, same clock
    input  wire [15:0] rx_strength,
    input  wire        rx_phase,
    // outputs
    output reg         motion_detect_out,
    output reg         direction_detect_out,
    output reg         pulse_start,
    output reg         ext_clk_enable,
    output reg  [11:0] pll_fcw_out,
    output reg  [1:0]  op_mode
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [3:0] spi_s;
    wire [7:0] strap_s;

    rdc_sync #(.WIDTH(4)) u_sync_spi (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .din     ({spi_sclk, spi_mosi, ~spi_cs_n, ~radar_reset_n}), // active-low pins enter inverted: a cleared chain reads idle
        .dout    (spi_s)
    );

    rdc_sync #(.WIDTH(8)) u_sync_strap (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .din     ({mode_strap_pin, thresh_strap_pin, hold_strap_pin, rate_strap_pin}),
        .dout    (strap_s)
    );

    wire sclk_s  = spi_s[3];
    wire mosi_s  = spi_s[2];
    wire cs_n_s  = ~spi_s[1];
    wire rrst_n_s = ~spi_s[0];

    // ----------------------------------------
    // strap capture after reset release
    // ----------------------------------------
    // the sync chain needs two edges before it shows the pins, so loading waits three
    reg  [1:0]  load_cnt;
    wire        strap_load = (load_cnt == 2'h2);
    reg  [15:0] thresh;
    reg  [15:0] adapt_reg;
    reg  [15:0] synth_reg;
    reg  [15:0] rate_reg;
    reg  [15:0] persist_reg;
    reg  [15:0] scale_reg;
    wire        serial_mode = op_mode[1];
    reg  [15:0] thr_def;
    reg  [15:0] hold_def;
    always @* begin
        case (strap_s[5:4])
            `RDC_QS_GND:  thr_def = `RDC_THR_DEF0;
            `RDC_QS_OPEN: thr_def = `RDC_THR_DEF1;
            `RDC_QS_RES:  thr_def = `RDC_THR_DEF2;
            default:      thr_def = `RDC_THR_DEF3;
        endcase
        case (strap_s[3:2])
            `RDC_QS_GND:  hold_def = `RDC_HOLD_DEF0;
            `RDC_QS_OPEN: hold_def = `RDC_HOLD_DEF1;
            `RDC_QS_RES:  hold_def = `RDC_HOLD_DEF2;
            default:      hold_def = `RDC_HOLD_DEF3;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            load_cnt <= 2'h0;
        end else if (!rrst_n_s) begin
            load_cnt <= 2'h0;
        end else if (load_cnt != 2'h3) begin
            load_cnt <= load_cnt + 2'h1;
        end
    end

    // ----------------------------------------
    // serial slave: mode 0, msb first
    // ----------------------------------------
    reg         sclk_d;
    reg  [4:0]  bit_cnt;
    reg  [23:0] rx_shift;
    reg  [15:0] tx_shift;
    reg  [15:0] rd_data;
    wire        sclk_rise = sclk_s & ~sclk_d;
    wire        sclk_fall = ~sclk_s & sclk_d;
    wire [23:0] rx_next = {rx_shift[22:0], mosi_s};
    wire        frame_done = sclk_rise && !cs_n_s && (bit_cnt == `RDC_FRAME_BITS - 5'd1);
    wire        wr_en = frame_done && rx_next[23] && serial_mode && (load_cnt == 2'h3);
    wire [6:0]  wr_addr = rx_next[22:16];
    wire [15:0] wr_data = rx_next[15:0];

    assign spi_miso_oe = ~cs_n_s;

    always @* begin
        case (rx_next[6:0])
            `RDC_ADDR_THRESH:  rd_data = thresh;
            `RDC_ADDR_ADAPT:   rd_data = adapt_reg;
            `RDC_ADDR_SYNTH:   rd_data = synth_reg;
            `RDC_ADDR_RATE:    rd_data = rate_reg;
            `RDC_ADDR_PERSIST: rd_data = persist_reg;
            `RDC_ADDR_SCALE:   rd_data = scale_reg;
            `RDC_ADDR_STATUS:  rd_data = {12'h000, op_mode, direction_detect_out, motion_detect_out};
            default:           rd_data = 16'h0000;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d   <= 1'b0;
            bit_cnt  <= 5'd0;
            rx_shift <= 24'h000000;
            tx_shift <= 16'h0000;
            spi_miso <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            if (cs_n_s) begin
                bit_cnt  <= 5'd0;
                spi_miso <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    rx_shift <= rx_next;
                    bit_cnt  <= frame_done ? 5'd0 : bit_cnt + 5'd1;
                    if (bit_cnt == `RDC_HDR_BITS - 5'd1) begin
                        tx_shift <= rd_data;
                    end
                end
                if (sclk_fall && bit_cnt >= `RDC_HDR_BITS) begin
                    spi_miso <= tx_shift[15];
                    tx_shift <= {tx_shift[14:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            op_mode        <= `RDC_QS_VDD;
            ext_clk_enable <= 1'b0;
            thresh         <= `RDC_THR_DEF3;
            adapt_reg      <= `RDC_RST_ADAPT;
            synth_reg      <= `RDC_RST_SYNTH;
            rate_reg       <= 16'h0000;
            persist_reg    <= `RDC_HOLD_DEF3;
            scale_reg      <= `RDC_RST_SCALE;
        end else if (strap_load) begin
            op_mode        <= strap_s[7:6];
            ext_clk_enable <= (strap_s[7:6] == `RDC_QS_RES);
            thresh         <= thr_def;
            persist_reg    <= hold_def;
            rate_reg       <= {4'h0, strap_s[1:0], 10'h000};
            adapt_reg      <= `RDC_RST_ADAPT;
            synth_reg      <= `RDC_RST_SYNTH;
            scale_reg      <= `RDC_RST_SCALE;
        end else if (wr_en) begin
            case (wr_addr)
                `RDC_ADDR_THRESH:  thresh      <= wr_data;
                `RDC_ADDR_ADAPT:   adapt_reg   <= wr_data;
                `RDC_ADDR_SYNTH:   synth_reg   <= wr_data;
                `RDC_ADDR_RATE:    rate_reg    <= wr_data;
                `RDC_ADDR_PERSIST: persist_reg <= wr_data;
                `RDC_ADDR_SCALE:   scale_reg   <= wr_data;
                default:           thresh      <= thresh;
            endcase
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pll_fcw_out <= 12'h000;
        end else begin
            pll_fcw_out <= synth_reg[`RDC_FCW_MSB:0];
        end
    end

    // ----------------------------------------
    // microsecond tick
    // ----------------------------------------
    reg  [15:0] tick_cnt;
    wire        tick = (tick_cnt == 16'h0000);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 16'h0000;
        end else if (tick) begin
            tick_cnt <= TICK_CYCLES[15:0] - 16'h0001;
        end else begin
            tick_cnt <= tick_cnt - 16'h0001;
        end
    end

    // ----------------------------------------
    // pulse repetition timer
    // ----------------------------------------
    reg  [19:0] prt_base;
    reg  [19:0] prt_cnt;
    wire        pulsed = (op_mode != `RDC_QS_GND);
    // adaptive timing drops the multiplier while motion is seen, trading power for response
    wire        adapt_fast = adapt_reg[`RDC_ADAPT_BIT] && motion_detect_out;
    wire [2:0]  prt_shift = adapt_fast ? 3'd0 : {1'b0, scale_reg[`RDC_SCALE_MSB:0]} + 3'd1;
    wire [19:0] prt_len = prt_base << prt_shift;

    always @* begin
        case (rate_reg[`RDC_RATE_MSB:`RDC_RATE_LSB])
            2'h0:    prt_base = `RDC_PRT_US0;
            2'h1:    prt_base = `RDC_PRT_US1;
            2'h2:    prt_base = `RDC_PRT_US2;
            default: prt_base = `RDC_PRT_US3;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prt_cnt     <= 20'h00000;
            pulse_start <= 1'b0;
        end else begin
            pulse_start <= 1'b0;
            if (!pulsed || load_cnt != 2'h3) begin
                prt_cnt <= 20'h00000;
            end else if (tick) begin
                if (prt_cnt == 20'h00000) begin
                    pulse_start <= 1'b1;
                    prt_cnt     <= prt_len - 20'h00001;
                end else begin
                    prt_cnt <= prt_cnt - 20'h00001;
                end
            end
        end
    end

    // ----------------------------------------
    // detector and hold
    // ----------------------------------------
    reg  [15:0] hold_cnt;
    // in cw mode the detector samples every tick, otherwise once per pulse
    wire        eval = pulsed ? pulse_start : tick;
    wire        hit = eval && (rx_strength >= thresh);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt             <= 16'h0000;
            motion_detect_out    <= 1'b0;
            direction_detect_out <= 1'b0;
        end else if (load_cnt != 2'h3) begin
            hold_cnt             <= 16'h0000;
            motion_detect_out    <= 1'b0;
            direction_detect_out <= 1'b0;
        end else if (hit) begin
            hold_cnt             <= persist_reg;
            motion_detect_out    <= 1'b1;
            direction_detect_out <= rx_phase;
        end else if (tick && motion_detect_out) begin
            if (hold_cnt == 16'h0000) begin
                motion_detect_out    <= 1'b0;
                direction_detect_out <= 1'b0;
            end else begin
                hold_cnt <= hold_cnt - 16'h0001;
            end
        end
    end

endmodule

/* File: rdc_radar_config_chk.sv */
`timescale 1ns/1ps

// ----------------------------------------
// port checker
// ----------------------------------------
module rdc_chk #(
    parameter TICK_CYCLES = 2
) (
    // clock and reset
    input wire       sys_clk,
    input wire       resetn,
    input wire       radar_reset_n,
    // serial pins
    input wire       spi_cs_n,
    input wire       spi_miso,
    input wire       spi_miso_oe,
    // straps and outputs
    input wire [1:0] mode_strap_pin,
    input wire       motion_detect_out,
    input wire       direction_detect_out,
    input wire       pulse_start,
    input wire       ext_clk_enable,
    input wire [1:0] op_mode
);
    localparam int MIN_GAP = 250 * TICK_CYCLES;
    logic [17:0] gap;
    logic        seen;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // a host reset restarts the pulse timer, so the gap check waits for a fresh pulse
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap  <= 18'h0;
            seen <= 1'b0;
        end else begin
            gap  <= pulse_start ? 18'h0 : gap + 18'h1;
            seen <= radar_reset_n & (seen | pulse_start);
        end
    end
    chk_reset_state: assert property ($rose(resetn) |-> op_mode == 2'h3 && !pulse_start)
        else $error("outputs not at reset state");
    chk_cs_idle: assert property (spi_cs_n [*6] |-> !spi_miso_oe && !spi_miso)
        else $error("serial out active while deselected");
    chk_oe_select: assert property ((!spi_cs_n) [*3] |-> spi_miso_oe)
        else $error("serial out not enabled while selected");
    chk_dir_motion: assert property (direction_detect_out |-> motion_detect_out)
        else $error("direction without motion");
    chk_ext_clk_on: assert property ((mode_strap_pin == 2'h2) [*6] |=> ext_clk_enable)
        else $error("external clock not enabled");
    chk_pulse_single: assert property (pulse_start |=> !pulse_start)
        else $error("pulse start too long");
    chk_pulse_gap: assert property (pulse_start && seen |-> gap >= MIN_GAP - 1)
        else $error("pulses too close");
    chk_cw_quiet: assert property (op_mode == 2'h0 |-> !pulse_start)
        else $error("pulse in continuous mode");
    chk_motion_cause: assert property ($rose(motion_detect_out) && op_mode != 2'h0 |->
        pulse_start || $past(pulse_start) || $past(pulse_start, 2) || $past(pulse_start, 3))
        else $error("motion without pulse");
    chk_motion_hold: assert property ($rose(motion_detect_out) && radar_reset_n |=> motion_detect_out)
        else $error("motion not held");
    cov_pulse: cover property (pulse_start);
    cov_motion: cover property ($rose(motion_detect_out));
    cov_ext: cover property (ext_clk_enable);
endmodule

bind rdc_radar_config rdc_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.sys_clk, .resetn, .radar_reset_n, .spi_cs_n,
    .spi_miso, .spi_miso_oe, .mode_strap_pin, .motion_detect_out, .direction_detect_out, .pulse_start,
    .ext_clk_enable, .op_mode);

/* File: rdc_host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// host side of the serial port
// ----------------------------------------
module rdc_host_model (
    // clock
    input  wire  sys_clk,
    // serial pins
    input  wire  spi_miso,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_cs_n
);
    int   half = 4;
    logic busy = 1'b0;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // an idle data line toggles so that a stale bit never looks valid
    always @(negedge sys_clk) if (!busy) spi_mosi <= ~spi_mosi;
    // mode 0, msb first; a larger half stretches both clock phases
    task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] rd);
        logic [23:0] f;
        f = {w, a, d};
        busy = 1'b1;
        @(negedge sys_clk) spi_cs_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 23; i >= 0; i--) begin
            spi_sclk <= 1'b0;
            spi_mosi <= f[i];
            repeat (half) @(negedge sys_clk);
            spi_sclk <= 1'b1;
            f[i] = spi_miso;
            repeat (half) @(negedge sys_clk);
        end
        spi_sclk <= 1'b0;
        repeat (3) @(negedge sys_clk);
        spi_cs_n <= 1'b1;
        rd = f[15:0];
        repeat (3) @(negedge sys_clk);
        busy = 1'b0;
    endtask
endmodule

/* File: rdc_radar_config_tb_top.sv */
`timescale 1ns/1ps
`include "rdc_consts.vh"

// ----------------------------------------
// bench: host model, design, reference registers
// ----------------------------------------
module rdc_radar_config_tb_top;
    localparam int TC = 2;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        radar_reset_n = 1'b1;
    logic [1:0]  mode_strap_pin = 2'h3;
    logic [1:0]  thresh_strap_pin = 2'h0;
    logic [1:0]  hold_strap_pin = 2'h0;
    logic [1:0]  rate_strap_pin = 2'h0;
    logic [15:0] rx_strength = 16'h0;
    logic        rx_phase = 1'b0;
    logic [15:0] rd;
    logic [15:0] v;
    wire         spi_sclk, spi_mosi, spi_cs_n, spi_miso, spi_miso_oe;
    wire         motion_detect_out, direction_detect_out, pulse_start, ext_clk_enable;
    wire [11:0]  pll_fcw_out;
    wire [1:0]   op_mode;
    int          err_count = 0;
    int          compares = 0;
    int          seed = 32'h9e1c;
    int          md;
    int          n;
    int          rm[int];
    int          thr[4] = '{16'h40, 16'h80, 16'h100, 16'h200};
    int          hld[4] = '{16'h64, 16'h3e8, 16'h2710, 16'hffff};
    int          base[4] = '{16'hfa, 16'h1f4, 16'h3e8, 16'h7d0};
    int          prt[7] = '{8'h00, 8'h10, 8'h01, 8'h20, 8'h02, 8'h30, 8'h03};
    int          adr[6] = '{`RDC_ADDR_THRESH, `RDC_ADDR_ADAPT, `RDC_ADDR_SYNTH,
                            `RDC_ADDR_RATE, `RDC_ADDR_PERSIST, `RDC_ADDR_SCALE};

    always #10 sys_clk = ~sys_clk;
    rdc_host_model host (.sys_clk, .spi_miso, .spi_sclk, .spi_mosi, .spi_cs_n);
    rdc_radar_config #(.TICK_CYCLES(TC)) dut (.sys_clk, .resetn, .spi_sclk, .spi_mosi, .spi_cs_n, .spi_miso,
        .spi_miso_oe, .radar_reset_n, .mode_strap_pin, .thresh_strap_pin, .hold_strap_pin, .rate_strap_pin,
        .rx_strength, .rx_phase, .motion_detect_out, .direction_detect_out, .pulse_start, .ext_clk_enable,
        .pll_fcw_out, .op_mode);

    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(int a, int d);
        host.xfer(1'b1, 7'(a), 16'(d), rd);
        // only serial modes accept writes, and only to the mapped registers
        if (md > 1 && rm.exists(a)) rm[a] = d & 16'hffff;
    endtask
    task automatic rdk(int a);
        host.xfer(1'b0, 7'(a), 16'h0, rd);
        chk("register", 16'(rm[a]), rd);
    endtask
    task automatic wait_pulse();
        n = 0;
        while (pulse_start !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 40000) begin
                chk("pulse_start", 16'h1, 16'h0);
                give_verdict();
            end
        end
        @(negedge sys_clk);
    endtask
    task automatic load();
        rm[`RDC_ADDR_THRESH] = thr[thresh_strap_pin];
        rm[`RDC_ADDR_PERSIST] = hld[hold_strap_pin];
        rm[`RDC_ADDR_RATE] = rate_strap_pin << 10;
        rm[`RDC_ADDR_SYNTH] = 0;
        rm[`RDC_ADDR_ADAPT] = 0;
        rm[`RDC_ADDR_SCALE] = 0;
    endtask
    task automatic boot(int m, int hs);
        @(negedge sys_clk);
        resetn <= 1'b0;
        mode_strap_pin <= 2'(m);
        thresh_strap_pin <= 2'($random(seed));
        hold_strap_pin <= 2'(hs);
        rate_strap_pin <= 2'($random(seed));
        repeat (8) @(negedge sys_clk);
        resetn <= 1'b1;
        md = m;
        repeat (6) @(negedge sys_clk);
        load();
    endtask

    initial begin
        for (int m = 0; m < 4; m++) begin
            boot(m, m == 0 ? 0 : $random(seed));
            chk("op_mode", 16'(m), 16'(op_mode));
            chk("ext_clk", 16'(m == 2), 16'(ext_clk_enable));
            chk("miso_oe", 16'h0, 16'(spi_miso_oe));
            wr(`RDC_ADDR_SYNTH, $random(seed));
            repeat (3) @(negedge sys_clk);
            chk("fcw", 16'(rm[`RDC_ADDR_SYNTH] & 16'hfff), 16'(pll_fcw_out));
            if (m == 0) begin
                rx_strength <= 16'(thr[thresh_strap_pin]);
                rx_phase <= 1'b1;
                repeat (TC + 4) @(negedge sys_clk);
                chk("cw_hit", 16'h3, {motion_detect_out, direction_detect_out});
                rx_strength <= 16'h0;
                n = 0;
                while (motion_detect_out === 1'b1 && n < 400) begin
                    @(negedge sys_clk);
                    n++;
                end
                chk("cw_hold", 16'h1, 16'(n >= 99 * TC && n <= 102 * TC));
                if (n >= 400) give_verdict();
            end else if (m > 1) foreach (adr[i]) rdk(adr[i]);
            $display("test mode %0d done", m);
        end
        // rate field cleared and scale kept at one so the next waits stay short
        foreach (adr[i]) wr(adr[i], $random(seed) & 16'hf3fc | 16'h1);
        wr(7'h03, 16'hffff);
        wr(`RDC_ADDR_STATUS, 16'hffff);
        host.half = 9;
        foreach (adr[i]) rdk(adr[i]);
        host.xfer(1'b0, `RDC_ADDR_STATUS, 16'h0, rd);
        chk("status", 16'hc, rd);
        host.xfer(1'b0, 7'h03, 16'h0, rd);
        chk("unmapped", 16'h0, rd);
        host.half = 4;
        $display("test registers done");
        v = 16'($random(seed)) | 16'h100;
        wr(`RDC_ADDR_THRESH, v);
        wr(`RDC_ADDR_PERSIST, 5);
        wr(`RDC_ADDR_ADAPT, 0);
        rx_strength <= v - 16'h1;
        wait_pulse();
        wait_pulse();
        repeat (4) @(negedge sys_clk);
        chk("miss", 16'h0, 16'(motion_detect_out));
        rx_strength <= v;
        wait_pulse();
        repeat (3) @(negedge sys_clk);
        chk("hit", 16'h3, {motion_detect_out, direction_detect_out});
        rx_strength <= 16'h0;
        n = 4;
        repeat (40) begin
            @(negedge sys_clk);
            n += (motion_detect_out === 1'b1);
        end
        chk("hold", 16'h1, 16'(n >= 5 * TC && n <= 7 * TC));
        $display("test detector done");
        foreach (prt[i]) begin
            wr(`RDC_ADDR_RATE, (prt[i] >> 4) << 10);
            wr(`RDC_ADDR_SCALE, prt[i] & 3);
            wait_pulse();
            wait_pulse();
            chk("prt", 16'((base[prt[i] >> 4] << ((prt[i] & 3) + 1)) * TC), 16'(n + 1));
        end
        wr(`RDC_ADDR_ADAPT, 16'h40);
        wr(`RDC_ADDR_PERSIST, 16'hffff);
        rx_strength <= 16'hffff;
        rx_phase <= 1'b0;
        repeat (3) wait_pulse();
        chk("adaptive", 16'(base[0] * TC), 16'(n + 1));
        chk("dir_low", 16'h2, {motion_detect_out, direction_detect_out});
        $display("test repetition done");
        rx_strength <= 16'h0;
        radar_reset_n <= 1'b0;
        repeat (6) @(negedge sys_clk);
        radar_reset_n <= 1'b1;
        repeat (8) @(negedge sys_clk);
        load();
        chk("cleared", 16'h0, 16'(motion_detect_out));
        rdk(`RDC_ADDR_PERSIST);
        rdk(`RDC_ADDR_THRESH);
        $display("test host reset done");
        give_verdict();
    end
endmodule
